// ==== clbc_cap_model.sv ====
/*
 * blanking capacitor on the ramp pin: a level in tenths of a volt that the
 * charge switch raises and the discharge switch lowers, with both thresholds.
 * assumes the switch outputs of clbc_top and the bench clock.
 */
`timescale 1ns/1ps
module clbc_cap_model (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic slow,
   input  wire logic ramp_charge_switch,
   input  wire logic ramp_discharge_switch,
   output logic      ramp_upper_comparator,
   output logic      ramp_lower_comparator
);
   int lvl = 0;
   // slow charging stands for a large capacitor or a loading resistor
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lvl <= 0;
      end else if (ramp_discharge_switch) begin
         lvl <= (lvl > 9) ? lvl - 9 : 0;
      end else if (ramp_charge_switch && lvl < 50) begin
         lvl <= lvl + (slow ? 1 : 6);
      end
   end
   assign ramp_upper_comparator = (lvl >= 45);
   assign ramp_lower_comparator = (lvl <= 9);
endmodule

// ==== clbc_pkg.sv ====
/*
 * package for the current limit and blanking control block: timing constants,
 * control states and interrupt register layout.
 * assumes a 10 MHz hclk; all blanking except the extended ramp, which counts capacitor cycles, is counted on hclk ticks.
 */
package clbc_pkg;
   localparam int CLK_PERIOD_NS = 100;
   // times in their own units, counts derived
   localparam int LEB_NORMAL_NS = 220;
   localparam int LEB_BURST_NS  = 180;
   localparam int BLANK_BASE_MS = 20;
   localparam int SPIKE_MS      = 30;
   // least times round up
   localparam int LEB_NORMAL_CYC = (LEB_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LEB_BURST_CYC  = (LEB_BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_BASE_CYC = BLANK_BASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SPIKE_CYC      = SPIKE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RAMP_COUNT_END = 256;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_STATUS  = 8'h04;
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN  = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;

   // ctrl fields
   localparam int CTRL_EXTEND_BIT = 0;
   localparam int CTRL_BURST_BIT  = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // interrupt bits
   localparam int IRQ_PEAK    = 0;
   localparam int IRQ_BURST   = 1;
   localparam int IRQ_RESTART = 2;
   localparam int IRQ_W       = 3;

   typedef enum logic [2:0] {
      CLBC_IDLE, CLBC_BASE, CLBC_CHARGE, CLBC_DISCHARGE, CLBC_SPIKE, CLBC_RESTART
   } clbc_ol_t;
endpackage

// ==== clbc_top.sv ====
/*
 * current limit and blanking control: switching pulse latch with leading edge
 * blanking, burst limit gating, burst entry blanking and the basic/extendable
 * overload blanking with its external ramp, plus an ahb-lite register slave.
 * assumes comparator outputs are already synchronous to hclk and that
 * hresetn is asserted at undervoltage lockout.
 */
// Notes on behaviour
// - sensed current above peak threshold clears the pulse latch at once.
// - comparators ignored 220 ns after turn-on, 180 ns in burst mode.
// - blanking gates peak, burst and amplifier comparators alike.
// - burst limit comparator acts only while burst mode is active.
// - burst and restart entry need their condition held through 20 ms.
// - only overload restart blanking may be extended by external capacitor.
// - extended mode after base expiry: block restart, enable counter, charge.
// - upper comparator at 4.5 V: count, stop charge, start discharge.
// - lower comparator at 0.9 V: stop discharge, charge again.
// - cycling repeats until count 256, then counter output goes high.
// - base expired and counter high: 30 ms spike blanking, then restart.
// - dynamic threshold: slope compensated comparator used in both modes.
// - oscillator sets latch; amplifier, soft start or peak limit reset it.
// - burst entered only if feedback below entry level for 20 ms.
`timescale 1ns/1ps
module clbc_top
   import clbc_pkg::*;
#(
   parameter int BLANK_BASE_CYCLES = BLANK_BASE_CYC,
   parameter int SPIKE_CYCLES      = SPIKE_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        osc_set,
   input  wire logic        peak_limit_comparator,
   input  wire logic        burst_limit_comparator,
   input  wire logic        current_sense_amplifier,
   input  wire logic        softstart_comparator,
   input  wire logic        feedback_below_burst,
   input  wire logic        feedback_burst_exit,
   input  wire logic        overload,
   input  wire logic        ramp_upper_comparator,
   input  wire logic        ramp_lower_comparator,
   output logic             gate_drive,
   output logic             ramp_charge_switch,
   output logic             ramp_discharge_switch,
   output logic             burst_active,
   output logic             auto_restart,
   output logic             irq
);
   localparam int BW = $clog2(SPIKE_CYCLES + 1);

   typedef struct packed {
      logic                switching_pulse_latch;
      logic [3:0]          leb_cnt;
      logic [BW-1:0]       burst_cnt;
      logic                burst;
      clbc_ol_t            ol;
      logic [BW-1:0]       ol_cnt;
      logic [8:0]          ramp_cnt;
      logic                charge;
      logic                discharge;
      logic [1:0]          ctrl;
      logic [IRQ_W-1:0]    irq_st;
      logic [IRQ_W-1:0]    irq_en;
      logic                dp_act;
      logic                dp_wr;
      logic [7:0]          dp_addr;
      logic [31:0]         rdata;
      logic                irq;
      logic                restart;
   } clbc_state_t;

   clbc_state_t s_reg, s_next;

   function automatic logic [BW-1:0] inc_sat(input logic [BW-1:0] v);
      return (v == '1) ? v : v + 1'b1;
   endfunction

   logic leb_done;
   logic limit_hit;
   logic [IRQ_W-1:0] ev;

   always_comb begin
      s_next = s_reg;
      ev     = '0;
      // leb expiry depends on the burst mode in the current cycle, not the mode at turn-on
      leb_done = s_reg.leb_cnt >= (s_reg.burst ? 4'(LEB_BURST_CYC) : 4'(LEB_NORMAL_CYC));
      // all sense paths share one blanking gate; inputs carry dynamic threshold
      // sense paths only act while the switch is on: a request left over from the
      // last pulse must not veto the next turn-on before blanking has run
      limit_hit = s_reg.switching_pulse_latch && leb_done
                  && (peak_limit_comparator
                  || (s_reg.burst && burst_limit_comparator)
                  || current_sense_amplifier
                  || softstart_comparator);

      // switching pulse latch; overload restart dominates the oscillator set
      if (limit_hit || s_reg.ol == CLBC_RESTART) begin
         s_next.switching_pulse_latch = 1'b0;
         if (s_reg.switching_pulse_latch && peak_limit_comparator && leb_done)
            ev[IRQ_PEAK] = 1'b1;
      end else if (osc_set && !s_reg.switching_pulse_latch) begin
         s_next.switching_pulse_latch = 1'b1;
         s_next.leb_cnt = '0;
      end
      if (s_reg.switching_pulse_latch && !leb_done)
         s_next.leb_cnt = s_reg.leb_cnt + 4'h1;

      // burst entry blanking
      if (s_reg.burst) begin
         if (feedback_burst_exit) begin
            s_next.burst = 1'b0;
            s_next.burst_cnt = '0;
         end
      end else if (!feedback_below_burst) begin
         s_next.burst_cnt = '0;
      end else if (s_reg.burst_cnt >= BW'(BLANK_BASE_CYCLES - 1)) begin
         s_next.burst = 1'b1;
         s_next.burst_cnt = '0;
         ev[IRQ_BURST] = 1'b1;
      end else begin
         s_next.burst_cnt = s_reg.burst_cnt + 1'b1;
      end
      if (!s_reg.ctrl[CTRL_BURST_BIT])
         s_next.burst = 1'b0;

      // overload blanking sequence
      case (s_reg.ol)
         CLBC_IDLE: begin
            s_next.ol_cnt = '0;
            s_next.ramp_cnt = '0;
            if (overload)
               s_next.ol = CLBC_BASE;
         end
         CLBC_BASE: begin
            s_next.ol_cnt = inc_sat(s_reg.ol_cnt);
            if (s_reg.ol_cnt >= BW'(BLANK_BASE_CYCLES - 1)) begin
               s_next.ol_cnt = '0;
               // only overload path has the extension
               if (s_reg.ctrl[CTRL_EXTEND_BIT]) begin
                  s_next.ol = CLBC_CHARGE;
                  s_next.charge = 1'b1;
               end else begin
                  s_next.ol = CLBC_SPIKE;
               end
            end
         end
         CLBC_CHARGE: begin
            if (ramp_upper_comparator) begin
               s_next.ramp_cnt = s_reg.ramp_cnt + 9'h1;
               s_next.charge = 1'b0;
               if (s_reg.ramp_cnt == 9'(RAMP_COUNT_END - 1)) begin
                  s_next.ol = CLBC_SPIKE;
               end else begin
                  s_next.discharge = 1'b1;
                  s_next.ol = CLBC_DISCHARGE;
               end
            end
         end
         CLBC_DISCHARGE: begin
            if (ramp_lower_comparator) begin
               s_next.discharge = 1'b0;
               s_next.charge = 1'b1;
               s_next.ol = CLBC_CHARGE;
            end
         end
         CLBC_SPIKE: begin
            s_next.ol_cnt = inc_sat(s_reg.ol_cnt);
            if (s_reg.ol_cnt >= BW'(SPIKE_CYCLES - 1)) begin
               s_next.ol = CLBC_RESTART;
               ev[IRQ_RESTART] = 1'b1;
            end
         end
         CLBC_RESTART: begin
            if (!overload)
               s_next.ol = CLBC_IDLE;
         end
         default: s_next.ol = CLBC_IDLE;
      endcase
      // overload gone before restart: clear everything
      if (!overload && s_reg.ol != CLBC_IDLE && s_reg.ol != CLBC_RESTART) begin
         s_next.ol = CLBC_IDLE;
         s_next.ol_cnt = '0;
         s_next.ramp_cnt = '0;
         s_next.charge = 1'b0;
         s_next.discharge = 1'b0;
      end

      // ahb-lite slave, zero wait states
      s_next.dp_act = 1'b0;
      if (s_reg.dp_act && s_reg.dp_wr) begin
         case (s_reg.dp_addr)
            ADDR_CTRL:    s_next.ctrl = hwdata[1:0];
            ADDR_IRQ_EN:  s_next.irq_en = hwdata[IRQ_W-1:0];
            ADDR_IRQ_CLR: s_next.irq_st = s_reg.irq_st & ~hwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
      // set wins over clear
      s_next.irq_st = s_next.irq_st | ev;
      if (hsel && hready && htrans[1]) begin
         s_next.dp_act = 1'b1;
         s_next.dp_wr = hwrite;
         s_next.dp_addr = haddr[7:0];
         case (haddr[7:0])
            ADDR_CTRL:   s_next.rdata = {30'h0, s_next.ctrl};
            // status word: state, switches and ramp count
            ADDR_STATUS: s_next.rdata = {15'h0, s_reg.ramp_cnt, 2'h0, s_reg.charge, s_reg.discharge,
                                         1'b0, s_reg.ol};
            ADDR_IRQ_ST: s_next.rdata = {29'h0, s_next.irq_st};
            ADDR_IRQ_EN: s_next.rdata = {29'h0, s_next.irq_en};
            default:     s_next.rdata = 32'h0000_0000;
         endcase
      end
      s_next.irq = |(s_next.irq_st & s_next.irq_en);
      // restart flag kept as its own flop so the output has no decode behind it
      s_next.restart = (s_next.ol == CLBC_RESTART);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= '{switching_pulse_latch: 1'b0, leb_cnt: '0, burst_cnt: '0, burst: 1'b0,
                    ol: CLBC_IDLE, ol_cnt: '0, ramp_cnt: '0, charge: 1'b0, discharge: 1'b0,
                    ctrl: CTRL_RESET, irq_st: '0, irq_en: '0, dp_act: 1'b0, dp_wr: 1'b0,
                    dp_addr: '0, rdata: '0, irq: 1'b0, restart: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   // every output except hreadyout and hresp is a flop of the state record
   assign gate_drive            = s_reg.switching_pulse_latch;
   assign ramp_charge_switch    = s_reg.charge;
   assign ramp_discharge_switch = s_reg.discharge;
   assign burst_active          = s_reg.burst;
   assign auto_restart          = s_reg.restart;
   assign irq                   = s_reg.irq;
   assign hrdata                = s_reg.rdata;
   assign hreadyout             = 1'b1;
   assign hresp                 = 1'b0;

   a_peak_cut: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate_drive && leb_done && peak_limit_comparator) |=> !gate_drive)
      else $error("peak limit did not end pulse");
   a_leb_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      ($rose(gate_drive) && !burst_active) |-> gate_drive [*2])
      else $error("pulse ended inside blanking");
   a_burst_gate: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate_drive && !burst_active && burst_limit_comparator && !peak_limit_comparator
       && !current_sense_amplifier && !softstart_comparator && !auto_restart) |=> gate_drive)
      else $error("burst limit acted outside burst");
   a_switch_excl: assert property (@(posedge hclk) disable iff (!hresetn)
      !(ramp_charge_switch && ramp_discharge_switch))
      else $error("charge and discharge both on");
   a_upper_step: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_reg.ol == CLBC_CHARGE && ramp_upper_comparator && overload && s_reg.ramp_cnt < 9'd255)
      |=> ramp_discharge_switch && !ramp_charge_switch)
      else $error("upper level did not start discharge");
   a_lower_step: assert property (@(posedge hclk) disable iff (!hresetn)
      (ramp_discharge_switch && ramp_lower_comparator && overload) |=> ramp_charge_switch)
      else $error("lower level did not restart charge");
   a_ol_clear: assert property (@(posedge hclk) disable iff (!hresetn)
      (!overload && !auto_restart) |=> s_reg.ramp_cnt == 9'h0 && s_reg.ol_cnt == '0)
      else $error("counters kept after overload cleared");
   sequence s_ramp_done;
      s_reg.ol == CLBC_CHARGE && ramp_upper_comparator && s_reg.ramp_cnt == 9'd255 && overload;
   endsequence
   a_spike_next: assert property (@(posedge hclk) disable iff (!hresetn)
      s_ramp_done |=> s_reg.ol == CLBC_SPIKE || !overload)
      else $error("spike blanking not started");
   a_no_early_rst: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(auto_restart) |-> $past(s_reg.ol) == CLBC_SPIKE)
      else $error("restart bypassed blanking");

   // blanking, turn-on and cut-off of the pulse
   a_leb_burst: assert property (@(posedge hclk) disable iff (!hresetn)
      ($rose(gate_drive) && burst_active) |-> gate_drive [*2])
      else $error("burst pulse ended inside blanking");
   a_blank_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate_drive && !leb_done && !auto_restart) |=> gate_drive)
      else $error("sense path acted inside blanking");
   a_amp_cut: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate_drive && leb_done && current_sense_amplifier) |=> !gate_drive)
      else $error("amplifier did not end pulse");
   a_burst_cut: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate_drive && leb_done && burst_active && burst_limit_comparator) |=> !gate_drive)
      else $error("burst limit did not end pulse");
   a_osc_turn_on: assert property (@(posedge hclk) disable iff (!hresetn)
      (!gate_drive && osc_set && !auto_restart) |=> gate_drive)
      else $error("oscillator did not set latch");
   a_restart_off: assert property (@(posedge hclk) disable iff (!hresetn)
      auto_restart |=> !gate_drive)
      else $error("gate driven in restart");

   // burst mode gating
   sequence s_burst_wait;
      !burst_active && feedback_below_burst && s_reg.burst_cnt < BW'(BLANK_BASE_CYCLES - 1);
   endsequence
   a_burst_blank: assert property (@(posedge hclk) disable iff (!hresetn)
      s_burst_wait |=> !burst_active)
      else $error("burst entered before blanking");
   a_burst_exit: assert property (@(posedge hclk) disable iff (!hresetn)
      (burst_active && feedback_burst_exit) |=> !burst_active)
      else $error("burst mode kept after exit");
   a_burst_soft: assert property (@(posedge hclk) disable iff (!hresetn)
      !s_reg.ctrl[CTRL_BURST_BIT] |=> !burst_active)
      else $error("burst entered while disabled");

   // overload blanking steps
   sequence s_base_end;
      s_reg.ol == CLBC_BASE && s_reg.ol_cnt >= BW'(BLANK_BASE_CYCLES - 1) && overload;
   endsequence
   a_ext_charge: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_base_end ##0 s_reg.ctrl[CTRL_EXTEND_BIT]) |=> ramp_charge_switch && !auto_restart)
      else $error("extended mode did not start charge");
   a_basic_spike: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_base_end ##0 !s_reg.ctrl[CTRL_EXTEND_BIT]) |=> s_reg.ol == CLBC_SPIKE && !ramp_charge_switch)
      else $error("basic mode did not start spike blanking");
   a_base_no_rst: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_reg.ol == CLBC_BASE) |=> !auto_restart)
      else $error("restart during base blanking");
   a_ramp_count: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_reg.ol == CLBC_CHARGE && ramp_upper_comparator && overload)
      |=> s_reg.ramp_cnt == $past(s_reg.ramp_cnt) + 9'h1)
      else $error("ramp count did not advance");
   a_dis_stop: assert property (@(posedge hclk) disable iff (!hresetn)
      (ramp_discharge_switch && ramp_lower_comparator && overload) |=> !ramp_discharge_switch)
      else $error("discharge kept at lower level");
   a_spike_len: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_reg.ol == CLBC_SPIKE && s_reg.ol_cnt < BW'(SPIKE_CYCLES - 1)) |=> !auto_restart)
      else $error("spike blanking cut short");
   a_ramp_start: assert property (@(posedge hclk) disable iff (!hresetn)
      (s_reg.ol == CLBC_IDLE) |=> s_reg.ramp_cnt == 9'h0)
      else $error("ramp count kept while idle");
endmodule

// ==== tb_top.sv ====
/*
 * self-checking bench for clbc_top: ahb-lite register access, pulse latch and
 * blanking, burst entry and exit, basic and extended overload blanking.
 * assumes the capacitor model clbc_cap_model on the ramp pin.
 */
`timescale 1ns/1ps
module tb_top
   import clbc_pkg::*;
;
   logic        hclk, hresetn, hsel, hwrite, osc_set, fb_lo, fb_exit, overload, slow;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  rq;
   logic        hreadyout, hresp, gate, chg, dis, burst, restart, irq, up, lo, rd_ph, dis_q;
   logic [15:0] rnd = 16'h002C;
   logic [31:0] exp_q[$], msk_q[$];
   int          num_errors = 0, tests_run = 0, n_dis = 0, nd, i;

   clbc_top #(.BLANK_BASE_CYCLES(20), .SPIKE_CYCLES(30)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .osc_set(osc_set), .peak_limit_comparator(rq[0]), .burst_limit_comparator(rq[1]),
      .current_sense_amplifier(rq[2]), .softstart_comparator(rq[3]), .feedback_below_burst(fb_lo),
      .feedback_burst_exit(fb_exit), .overload(overload), .ramp_upper_comparator(up),
      .ramp_lower_comparator(lo), .gate_drive(gate), .ramp_charge_switch(chg),
      .ramp_discharge_switch(dis), .burst_active(burst), .auto_restart(restart), .irq(irq));
   clbc_cap_model u_cap (.hclk(hclk), .hresetn(hresetn), .slow(slow), .ramp_charge_switch(chg),
      .ramp_discharge_switch(dis), .ramp_upper_comparator(up), .ramp_lower_comparator(lo));

   initial begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task end_sim();
      if (num_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task to();
      num_errors++;
      end_sim();
   endtask

   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic hs();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) to();
   endtask

   // for a read, d carries the expected value under mask m
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      hs();
      htrans <= 2'b00;
      hwdata <= d;
      rd_ph <= ~w;
      if (!w) begin
         exp_q.push_back(d & m);
         msk_q.push_back(m);
      end
      hs();
      rd_ph <= 1'b0;
   endtask

   always @(posedge hclk) begin
      if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
         chk(exp_q.pop_front(), hrdata & msk_q.pop_front());
      end
   end

   always @(posedge hclk) begin
      dis_q <= dis;
      if (dis === 1'b1 && dis_q !== 1'b1) n_dis <= n_dis + 1;
   end

   // one switching cycle with reset source s held from the start
   task automatic pulse(input int s, input int hi, input logic e);
      osc_set <= 1'b1;
      rq[s] <= 1'b1;
      @(posedge hclk);
      osc_set <= 1'b0;
      cyc(hi);
      #1 chk(32'h0000_0001, gate);
      cyc(2);
      #1 chk({31'h0, e}, gate);
      @(posedge hclk);
      rq <= 4'h1;
      cyc(6);
      rq <= 4'h0;
      @(posedge hclk);
   endtask

   initial begin
      #5000000 to();
   end

   initial begin
      {hresetn, hwrite, htrans, osc_set, rq, fb_lo, fb_exit, overload, rd_ph, slow} = '0;
      {haddr, hwdata} = '0;
      hsel = 1'b1;
      hsize = 3'b010;
      cyc(8);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(0, ADDR_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
      ahb(0, ADDR_IRQ_ST, 32'h0000_0000, 32'hFFFF_FFFF);
      rnd = lfsr(rnd);
      ahb(1, 8'h40, {rnd, ~rnd}, 32'h0000_0000);
      ahb(0, 8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
      ahb(1, ADDR_IRQ_EN, 32'h0000_0007, 32'h0000_0000);
      for (i = 0; i < 4; i++) pulse(i, 2, i == 1);
      ahb(0, ADDR_IRQ_ST, 32'h0000_0001, 32'h0000_0001);
      chk(32'h0000_0001, irq);
      ahb(1, ADDR_IRQ_CLR, 32'h0000_0007, 32'h0000_0000);
      cyc(1);
      #1 chk(32'h0000_0000, irq);
      @(posedge hclk);
      // burst entry with a dropout inside the blanking time
      ahb(1, ADDR_CTRL, 32'h0000_0002, 32'h0000_0000);
      fb_lo <= 1'b1;
      cyc(10);
      fb_lo <= 1'b0;
      cyc(2);
      fb_lo <= 1'b1;
      cyc(15);
      #1 chk(32'h0000_0000, burst);
      cyc(10);
      #1 chk(32'h0000_0001, burst);
      @(posedge hclk);
      for (i = 0; i < 4; i++) pulse(i, 1, 1'b0);
      fb_lo <= 1'b0;
      fb_exit <= 1'b1;
      cyc(4);
      #1 chk(32'h0000_0000, burst);
      @(posedge hclk);
      fb_exit <= 1'b0;
      ahb(1, ADDR_CTRL, 32'h0000_0000, 32'h0000_0000);
      ahb(1, ADDR_IRQ_CLR, 32'h0000_0007, 32'h0000_0000);
      ahb(1, ADDR_IRQ_EN, 32'h0000_0004, 32'h0000_0000);
      // basic overload blanking, first attempt withdrawn early
      overload <= 1'b1;
      cyc(15);
      overload <= 1'b0;
      cyc(2);
      overload <= 1'b1;
      cyc(45);
      #1 chk(32'h0000_0000, restart);
      cyc(10);
      #1 chk(32'h0000_0001, restart);
      chk(32'h0000_0000, chg);
      chk(32'h0000_0001, irq);
      @(posedge hclk);
      ahb(1, ADDR_IRQ_EN, 32'h0000_0000, 32'h0000_0000);
      cyc(1);
      #1 chk(32'h0000_0000, irq);
      @(posedge hclk);
      ahb(1, ADDR_IRQ_EN, 32'h0000_0004, 32'h0000_0000);
      ahb(0, ADDR_IRQ_ST, 32'h0000_0004, 32'h0000_0004);
      ahb(1, ADDR_IRQ_CLR, 32'h0000_0004, 32'h0000_0000);
      cyc(1);
      #1 chk(32'h0000_0000, irq);
      @(posedge hclk);
      // lockout in mid-run
      overload <= 1'b0;
      hresetn <= 1'b0;
      cyc(2);
      hresetn <= 1'b1;
      @(posedge hclk);
      #1 chk(32'h0000_0000, restart);
      @(posedge hclk);
      // extended blanking through the capacitor ramp
      ahb(1, ADDR_CTRL, 32'h0000_0001, 32'h0000_0000);
      nd = n_dis;
      overload <= 1'b1;
      cyc(15);
      #1 chk(32'h0000_0000, chg);
      cyc(8);
      #1 chk(32'h0000_0001, chg);
      chk(32'h0000_0000, restart);
      for (i = 0; restart !== 1'b1; i++) begin
         if (i > 20000) to();
         @(posedge hclk);
         rnd = lfsr(rnd);
         slow <= rnd[0];
      end
      chk(32'(RAMP_COUNT_END - 1), 32'(n_dis - nd));
      ahb(0, ADDR_STATUS, 32'h0001_0005, 32'h0001_FFFF);
      end_sim();
   end
endmodule
